// ==== core/dual_fast_digital_input.sv ====
// Dual fast digital input: filters, input byte, parameters, edge events and indicators
`timescale 1ns/1ps
module dual_fast_digital_input
  import dual_input_pkg::*;
#(
  parameter int DELAY_342_COUNT  = DELAY_342_CYCLES,
  parameter int DELAY_2731_COUNT = DELAY_2731_CYCLES,
  parameter int BLINK_HALF_COUNT = BLINK_HALF_CYCLES,
  parameter int CNT_W            = 16
)(
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic                    clk_en,
  input  wire logic [NUM_CHANNELS-1:0] input_channel,
  input  wire logic                    bus_power_ok,
  input  wire logic                    bus_comm_ok,
  input  wire logic                    module_error,
  input  wire logic                    config_error,
  input  wire logic                    system_stop,
  input  wire logic                    param_wr,
  input  wire logic [2:0]              param_index,
  input  wire logic [7:0]              param_wdata,
  output logic [7:0]                   param_rdata,
  output logic                         param_reject,
  output logic [7:0]                   input_levels,
  output logic                         process_event,
  output logic [7:0]                   process_event_channels,
  output logic [7:0]                   process_event_levels,
  output logic                         diag_interrupt,
  output logic                         run_indicator,
  output logic                         fault_indicator,
  output logic [NUM_CHANNELS-1:0]      channel_indicator
);

  localparam int BLINK_W = 32;
  initial
  begin
    if (DELAY_2731_COUNT >= 2 ** CNT_W || DELAY_342_COUNT >= 2 ** CNT_W)
      $error("dual_fast_digital_input: CNT_W too narrow for the filter delays");
    if (DELAY_342_COUNT < 1 || DELAY_2731_COUNT < 1 || BLINK_HALF_COUNT < 1)
      $error("dual_fast_digital_input: counts must be at least one");
  end

  logic [7:0]              diag_interrupt_enable;
  logic [7:0]              channel0_filter_delay;
  logic [7:0]              channel1_filter_delay;
  logic [7:0]              rising_edge_irq_mask;
  logic [7:0]              falling_edge_irq_mask;
  logic [NUM_CHANNELS-1:0] level;
  logic [NUM_CHANNELS-1:0] level_prev;
  logic [NUM_CHANNELS-1:0] rise_hit;
  logic [NUM_CHANNELS-1:0] fall_hit;
  logic [CNT_W-1:0]        delay_cycles [NUM_CHANNELS];
  logic [BLINK_W-1:0]      blink_cnt;
  logic                    blink_phase;
  led_mode_t               led_mode;
  led_mode_t               next_led_mode;
  logic                    code_ok;
  logic                    diag_wr_ok;

  function automatic logic [CNT_W-1:0] code_to_cycles(input logic [7:0] code);
    case (code)
      DELAY_CODE_1US:    code_to_cycles = CNT_W'(DELAY_1_CYCLES);
      DELAY_CODE_3US:    code_to_cycles = CNT_W'(DELAY_3_CYCLES);
      DELAY_CODE_10US:   code_to_cycles = CNT_W'(DELAY_10_CYCLES);
      DELAY_CODE_86US:   code_to_cycles = CNT_W'(DELAY_86_CYCLES);
      DELAY_CODE_342US:  code_to_cycles = CNT_W'(DELAY_342_COUNT);
      DELAY_CODE_2731US: code_to_cycles = CNT_W'(DELAY_2731_COUNT);
      default:           code_to_cycles = CNT_W'(DELAY_3_CYCLES);
    endcase
  endfunction : code_to_cycles

  // Parameter writes
  assign code_ok    = param_wdata inside {DELAY_CODE_1US, DELAY_CODE_3US, DELAY_CODE_10US,
                                          DELAY_CODE_86US, DELAY_CODE_342US, DELAY_CODE_2731US};
  assign diag_wr_ok = system_stop && (param_wdata == DIAG_CODE_OFF || param_wdata == DIAG_CODE_ON);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      diag_interrupt_enable <= DIAG_INTERRUPT_ENABLE_RESET;
      channel0_filter_delay <= CH_DELAY_RESET;
      channel1_filter_delay <= CH_DELAY_RESET;
      rising_edge_irq_mask  <= RISE_MASK_RESET;
      falling_edge_irq_mask <= FALL_MASK_RESET;
      param_reject          <= 1'b0;
    end
    else if (clk_en)
    begin
      param_reject <= 1'b0;
      if (param_wr)
      begin
        case (param_index)
          PARAM_IDX_DIAG_INTERRUPT_ENABLE:
            if (diag_wr_ok)
              diag_interrupt_enable <= param_wdata;
            else
              param_reject <= 1'b1;
          PARAM_IDX_CH0_DELAY:
            if (code_ok)
              channel0_filter_delay <= param_wdata;
            else
              param_reject <= 1'b1;
          PARAM_IDX_CH1_DELAY:
            if (code_ok)
              channel1_filter_delay <= param_wdata;
            else
              param_reject <= 1'b1;
          PARAM_IDX_RISE_MASK: rising_edge_irq_mask  <= {6'h00, param_wdata[CH1_BIT:CH0_BIT]};
          PARAM_IDX_FALL_MASK: falling_edge_irq_mask <= {6'h00, param_wdata[CH1_BIT:CH0_BIT]};
          default:             param_reject          <= 1'b1;
        endcase
      end
    end
  end

  // Parameter readback, one cycle behind the index
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      param_rdata <= 8'h00;
    end
    else if (clk_en)
    begin
      case (param_index)
        PARAM_IDX_DIAG_INTERRUPT_ENABLE:   param_rdata <= diag_interrupt_enable;
        PARAM_IDX_CH0_DELAY: param_rdata <= channel0_filter_delay;
        PARAM_IDX_CH1_DELAY: param_rdata <= channel1_filter_delay;
        PARAM_IDX_RISE_MASK: param_rdata <= rising_edge_irq_mask;
        PARAM_IDX_FALL_MASK: param_rdata <= falling_edge_irq_mask;
        default:             param_rdata <= 8'h00;
      endcase
    end
  end

  // Per-channel filters
  assign delay_cycles[0] = code_to_cycles(channel0_filter_delay);
  assign delay_cycles[1] = code_to_cycles(channel1_filter_delay);

  for (genvar ch = 0; ch < NUM_CHANNELS; ch++)
  begin : g_filter
    input_filter #(.CNT_W (CNT_W)) input_filter_i (
      .ref_clk      (ref_clk),
      .rst_n        (rst_n),
      .clk_en       (clk_en),
      .raw_pin      (input_channel[ch]),
      .delay_cycles (delay_cycles[ch]),
      .level        (level[ch])
    );
  end

  // Input image byte; the output image is empty so nothing is consumed
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      input_levels <= 8'h00;
    end
    else if (clk_en)
    begin
      input_levels <= {6'h00, level[CH1_BIT], level[CH0_BIT]};
    end
  end

  // Edge events from the filtered levels, gated by the masks
  assign rise_hit = level & ~level_prev & rising_edge_irq_mask[NUM_CHANNELS-1:0];
  assign fall_hit = ~level & level_prev & falling_edge_irq_mask[NUM_CHANNELS-1:0];

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      level_prev             <= '0;
      process_event          <= 1'b0;
      process_event_channels <= 8'h00;
      process_event_levels   <= 8'h00;
    end
    else if (clk_en)
    begin
      level_prev    <= level;
      process_event <= |(rise_hit | fall_hit);
      if (|(rise_hit | fall_hit))
      begin
        process_event_channels <= {6'h00, rise_hit | fall_hit};
        process_event_levels   <= {6'h00, level};
      end
    end
  end

  // Diagnostic interrupt follows the module error while enabled
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      diag_interrupt <= 1'b0;
    end
    else if (clk_en)
    begin
      diag_interrupt <= module_error && (diag_interrupt_enable == DIAG_CODE_ON);
    end
  end

  // Blink timebase for the fault indicator
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      blink_cnt   <= '0;
      blink_phase <= 1'b0;
    end
    else if (clk_en)
    begin
      if (led_mode != LED_BLINK || blink_cnt == BLINK_W'(BLINK_HALF_COUNT - 1))
      begin
        blink_cnt   <= '0;
        blink_phase <= (led_mode == LED_BLINK) ? ~blink_phase : 1'b1;
      end
      else
        blink_cnt <= blink_cnt + 1'b1;
    end
  end

  // Indicator mode: supply failure over configuration error over status
  assign next_led_mode = !bus_power_ok ? LED_DARK : (config_error ? LED_BLINK : LED_STATUS);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      led_mode <= LED_DARK;
    end
    else if (clk_en)
    begin
      led_mode <= next_led_mode;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      run_indicator     <= 1'b0;
      fault_indicator   <= 1'b0;
      channel_indicator <= '0;
    end
    else if (clk_en)
    begin
      channel_indicator <= level;
      case (led_mode)
        LED_DARK:
        begin
          run_indicator   <= 1'b0;
          fault_indicator <= 1'b0;
        end
        LED_BLINK:
        begin
          run_indicator   <= bus_comm_ok;
          fault_indicator <= blink_phase;
        end
        LED_STATUS:
        begin
          run_indicator   <= bus_comm_ok;
          fault_indicator <= module_error;
        end
        default:
        begin
          run_indicator   <= 1'b0;
          fault_indicator <= 1'b0;
        end
      endcase
    end
  end

  input_byte_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en |=> (input_levels == {6'h00, $past(level)}))
    else $error("input byte does not mirror the filtered levels");
  supply_dark_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && !bus_power_ok) ##1 clk_en |=> (!run_indicator && !fault_indicator))
    else $error("indicators lit after bus supply failure");
  run_status_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && bus_power_ok && !config_error) ##1 (clk_en && led_mode == LED_STATUS)
      |=> (run_indicator == $past(bus_comm_ok) && fault_indicator == $past(module_error)))
    else $error("run or fault indicator wrong in status mode");
  channel_led_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && led_mode == LED_STATUS) |=> (channel_indicator == $past(level)))
    else $error("channel indicator does not follow its input");
  blink_rate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && led_mode == LED_BLINK && blink_cnt == BLINK_W'(BLINK_HALF_COUNT - 1))
      ##1 (clk_en && led_mode == LED_BLINK) |=> (fault_indicator != $past(fault_indicator)))
    else $error("fault indicator did not toggle at half period");
  bad_code_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && param_wr && param_index == PARAM_IDX_CH0_DELAY && !code_ok)
      |=> (param_reject && $stable(channel0_filter_delay)))
    else $error("invalid delay code was accepted");
  diag_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && param_wr && param_index == PARAM_IDX_DIAG_INTERRUPT_ENABLE && !system_stop)
      |=> $stable(diag_interrupt_enable))
    else $error("diagnostic enable changed outside stop state");
  diag_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    diag_interrupt |-> (diag_interrupt_enable == DIAG_CODE_ON || $past(diag_interrupt_enable) == DIAG_CODE_ON))
    else $error("diagnostic interrupt raised while disabled");
  edge_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && level[CH0_BIT] && !level_prev[CH0_BIT] && !rising_edge_irq_mask[CH0_BIT])
      |=> !(process_event && process_event_channels[CH0_BIT]))
    else $error("masked rising edge reported");
  mask_reserved_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rising_edge_irq_mask[7:2] == 6'h00) && (falling_edge_irq_mask[7:2] == 6'h00))
    else $error("reserved mask bits set");

endmodule : dual_fast_digital_input

// ==== core/dual_input_pkg.sv ====
// Constants shared by the dual fast digital input block
package dual_input_pkg;

  // Clock
  localparam int          CLK_HZ              = 20_000_000;
  localparam int          US_PER_S            = 1_000_000;

  // Channels and bit positions
  localparam int          NUM_CHANNELS        = 2;
  localparam int          CH0_BIT             = 0;
  localparam int          CH1_BIT             = 1;

  // Input image: one byte at offset zero, nothing in the output image
  localparam logic [7:0]  INPUT_LEVELS_OFFSET = 8'h00;
  localparam int          INPUT_IMAGE_BYTES   = 1;
  localparam int          OUTPUT_IMAGE_BYTES  = 0;

  // Parameter byte index within the parameter record set
  localparam logic [2:0]  PARAM_IDX_DIAG_INTERRUPT_ENABLE   = 3'h0;
  localparam logic [2:0]  PARAM_IDX_CH0_DELAY = 3'h1;
  localparam logic [2:0]  PARAM_IDX_CH1_DELAY = 3'h2;
  localparam logic [2:0]  PARAM_IDX_RISE_MASK = 3'h3;
  localparam logic [2:0]  PARAM_IDX_FALL_MASK = 3'h4;

  // Values after reset
  localparam logic [7:0]  DIAG_INTERRUPT_ENABLE_RESET       = 8'h00;
  localparam logic [7:0]  CH_DELAY_RESET      = 8'h02;
  localparam logic [7:0]  RISE_MASK_RESET     = 8'h00;
  localparam logic [7:0]  FALL_MASK_RESET     = 8'h00;

  // Diagnostic interrupt enable codes
  localparam logic [7:0]  DIAG_CODE_OFF       = 8'h00;
  localparam logic [7:0]  DIAG_CODE_ON        = 8'h40;

  // Filter delay codes and their times in microseconds
  localparam logic [7:0]  DELAY_CODE_1US      = 8'h00;
  localparam logic [7:0]  DELAY_CODE_3US      = 8'h02;
  localparam logic [7:0]  DELAY_CODE_10US     = 8'h04;
  localparam logic [7:0]  DELAY_CODE_86US     = 8'h07;
  localparam logic [7:0]  DELAY_CODE_342US    = 8'h09;
  localparam logic [7:0]  DELAY_CODE_2731US   = 8'h0c;
  localparam int          DELAY_1_US          = 1;
  localparam int          DELAY_3_US          = 3;
  localparam int          DELAY_10_US         = 10;
  localparam int          DELAY_86_US         = 86;
  localparam int          DELAY_342_US        = 342;
  localparam int          DELAY_2731_US       = 2731;
  localparam int          DELAY_1_CYCLES      = DELAY_1_US * (CLK_HZ / US_PER_S);
  localparam int          DELAY_3_CYCLES      = DELAY_3_US * (CLK_HZ / US_PER_S);
  localparam int          DELAY_10_CYCLES     = DELAY_10_US * (CLK_HZ / US_PER_S);
  localparam int          DELAY_86_CYCLES     = DELAY_86_US * (CLK_HZ / US_PER_S);
  localparam int          DELAY_342_CYCLES    = DELAY_342_US * (CLK_HZ / US_PER_S);
  localparam int          DELAY_2731_CYCLES   = DELAY_2731_US * (CLK_HZ / US_PER_S);

  // Fault indicator blink rate
  localparam int          BLINK_HZ            = 2;
  localparam int          BLINK_HALF_CYCLES   = CLK_HZ / (2 * BLINK_HZ);

  // Indicator modes
  typedef enum logic [2:0] {
    LED_DARK   = 3'b001,
    LED_STATUS = 3'b010,
    LED_BLINK  = 3'b100
  } led_mode_t;

endpackage : dual_input_pkg

// ==== core/input_filter.sv ====
// Two-stage synchroniser and stable-time filter for one input channel
`timescale 1ns/1ps
module input_filter
  import dual_input_pkg::*;
#(
  parameter int CNT_W = 16
)(
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             raw_pin,
  input  wire logic [CNT_W-1:0] delay_cycles,
  output logic                  level
);

  logic             sync_meta;
  logic             sync_pin;
  logic [CNT_W-1:0] stable_cnt;
  logic [CNT_W-1:0] next_cnt;

  initial
  begin
    if (CNT_W < 2 || CNT_W > 31)
      $error("input_filter: CNT_W out of range");
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sync_meta <= 1'b0;
      sync_pin  <= 1'b0;
    end
    else if (clk_en)
    begin
      sync_meta <= raw_pin;
      sync_pin  <= sync_meta;
    end
  end

  assign next_cnt = stable_cnt + 1'b1;

  // New level taken only after it has held for the full delay, either direction
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      stable_cnt <= '0;
      level      <= 1'b0;
    end
    else if (clk_en)
    begin
      if (sync_pin == level)
      begin
        stable_cnt <= '0;
      end
      else if (next_cnt >= delay_cycles)
      begin
        level      <= sync_pin;
        stable_cnt <= '0;
      end
      else
      begin
        stable_cnt <= next_cnt;
      end
    end
  end

  // Helper: own count of differing cycles, restarts once the delay is served
  logic [CNT_W-1:0] differ_cnt;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || (clk_en && sync_pin == level))
    begin
      differ_cnt <= '0;
    end
    else if (clk_en)
    begin
      differ_cnt <= (differ_cnt + 1'b1 >= delay_cycles) ? '0 : differ_cnt + 1'b1;
    end
  end

  filter_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && $changed(level) && $past(clk_en)) |-> ($past(differ_cnt) + 1'b1 >= $past(delay_cycles)))
    else $error("filtered level changed before the delay ran out");

  filter_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && sync_pin != level && differ_cnt + 1'b1 >= delay_cycles) |=> (level == $past(sync_pin)))
    else $error("filtered level did not follow after the delay");

endmodule : input_filter

// ==== testbench/dual_fast_digital_input_bench.sv ====
// Self-checking bench for the dual fast digital input block
`timescale 1ns/1ps
module dual_fast_digital_input_bench;
  import dual_input_pkg::*;
  localparam int N342 = 40;
  localparam int N2731 = 80;
  localparam int HALF = 10;
  logic       ref_clk, rst_n, clk_en, bus_power_ok, bus_comm_ok, module_error, config_error;
  logic       system_stop, param_wr, param_reject, process_event, diag_interrupt;
  logic       run_indicator, fault_indicator;
  logic [1:0] pins, lvl, channel_indicator;
  logic [2:0] param_index;
  logic [7:0] param_wdata, param_rdata, input_levels, process_event_channels, process_event_levels;
  int         mismatches, n_tests, cyc, ev_cnt;

  dual_fast_digital_input #(.DELAY_342_COUNT(N342), .DELAY_2731_COUNT(N2731), .BLINK_HALF_COUNT(HALF))
    dual_fast_digital_input_i (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .input_channel(pins),
    .bus_power_ok(bus_power_ok), .bus_comm_ok(bus_comm_ok), .module_error(module_error),
    .config_error(config_error), .system_stop(system_stop), .param_wr(param_wr),
    .param_index(param_index), .param_wdata(param_wdata), .param_rdata(param_rdata),
    .param_reject(param_reject), .input_levels(input_levels), .process_event(process_event),
    .process_event_channels(process_event_channels), .process_event_levels(process_event_levels),
    .diag_interrupt(diag_interrupt), .run_indicator(run_indicator), .fault_indicator(fault_indicator),
    .channel_indicator(channel_indicator));

  head_station_model head_station_model_i (.ref_clk(ref_clk), .param_rdata(param_rdata),
    .param_reject(param_reject), .system_stop(system_stop), .param_wr(param_wr),
    .param_index(param_index), .param_wdata(param_wdata));

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cyc++;
    if (process_event === 1'b1)
      ev_cnt++;
    if (cyc == 40000)
    begin
      mismatches++;
      summarize();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic t_reg;
    logic [7:0] d;
    bit         rj;
    logic [7:0] dflt [6] = '{8'h00, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++)
    begin
      head_station_model_i.get(3'(i), d);
      check(d, dflt[i], "default");
    end
    head_station_model_i.put(3'h1, 8'h05, 1'b1, rj);
    check(8'(rj), 8'h01, "bad code");
    head_station_model_i.get(3'h1, d);
    check(d, 8'h02, "kept code");
    head_station_model_i.put(3'h0, DIAG_CODE_ON, 1'b0, rj);
    check(8'(rj), 8'h01, "diag in run");
    head_station_model_i.put(3'h6, 8'h01, 1'b1, rj);
    check(8'(rj), 8'h01, "bad index");
    head_station_model_i.put(3'h3, 8'hff, 1'b1, rj);
    head_station_model_i.get(3'h3, d);
    check(d, 8'h03, "mask bits");
    head_station_model_i.put(3'h3, 8'h00, 1'b1, rj);
    $display("t_reg done");
  endtask : t_reg

  task automatic t_diag;
    bit rj;
    module_error = 1'b1;
    head_station_model_i.put(3'h0, DIAG_CODE_ON, 1'b1, rj);
    check({7'h00, diag_interrupt}, 8'h01, "diag on");
    head_station_model_i.put(3'h0, DIAG_CODE_OFF, 1'b1, rj);
    check({7'h00, diag_interrupt}, 8'h00, "diag off");
    module_error = 1'b0;
    $display("t_diag done");
  endtask : t_diag

  task automatic t_leds;
    logic [4:0] tbl [4] = '{5'b11010, 5'b11111, 5'b10101, 5'b01100};
    int         k;
    for (int i = 0; i < 4; i++)
    begin
      {bus_power_ok, bus_comm_ok, module_error} = tbl[i][4:2];
      repeat (4) @(negedge ref_clk);
      check({6'h00, run_indicator, fault_indicator}, {6'h00, tbl[i][1:0]}, "leds");
    end
    {bus_power_ok, bus_comm_ok, module_error, config_error} = 4'b1101;
    repeat (4) @(negedge ref_clk);
    k = 0;
    for (logic f = fault_indicator; f === fault_indicator && k < 3 * HALF; k++)
      @(negedge ref_clk);
    k = 0;
    for (logic f = fault_indicator; f === fault_indicator && k < 3 * HALF; k++)
      @(negedge ref_clk);
    check(8'(k), 8'(HALF), "blink half");
    clk_en = 1'b0;
    k = fault_indicator;
    repeat (3 * HALF) @(negedge ref_clk);
    check(8'(fault_indicator), 8'(k), "frozen");
    clk_en = 1'b1;
    config_error = 1'b0;
    repeat (4) @(negedge ref_clk);
    $display("t_leds done");
  endtask : t_leds

  task automatic flip(input int ch, input int n);
    pins[ch] = ~pins[ch];
    // Byte turns after two synchroniser cycles, the delay and its own register
    repeat (n + 2) @(negedge ref_clk);
    check(input_levels, {6'h00, lvl}, "early");
    lvl[ch] = pins[ch];
    repeat (2) @(negedge ref_clk);
    check(input_levels, {6'h00, lvl}, "settled");
    check({6'h00, channel_indicator}, {6'h00, lvl}, "chan led");
  endtask : flip

  task automatic t_filter(input int ch, input logic [7:0] code, input int n);
    bit         rj;
    logic [7:0] d;
    head_station_model_i.put(3'(ch + 1), code, 1'b1, rj);
    head_station_model_i.get(3'(ch + 1), d);
    check(d, code, "code");
    for (int e = 0; e < 2; e++)
    begin
      pins[ch] = ~pins[ch];
      repeat (n / 2) @(negedge ref_clk);
      pins[ch] = ~pins[ch];
      repeat (n + 4) @(negedge ref_clk);
      check(input_levels, {6'h00, lvl}, "glitch");
      flip(ch, n);
    end
    $display("t_filter done");
  endtask : t_filter

  task automatic t_events;
    bit rj;
    int e0;
    head_station_model_i.put(3'h1, DELAY_CODE_1US, 1'b1, rj);
    head_station_model_i.put(3'h2, DELAY_CODE_1US, 1'b1, rj);
    head_station_model_i.put(3'h3, 8'h01, 1'b1, rj);
    head_station_model_i.put(3'h4, 8'h02, 1'b1, rj);
    e0 = ev_cnt;
    flip(0, DELAY_1_CYCLES);
    check(process_event_channels, 8'h01, "ev chan");
    check(process_event_levels, {6'h00, lvl}, "ev level");
    flip(1, DELAY_1_CYCLES);
    flip(0, DELAY_1_CYCLES);
    flip(1, DELAY_1_CYCLES);
    check(process_event_channels, 8'h02, "ev chan");
    check(8'(ev_cnt - e0), 8'h02, "ev count");
    $display("t_events done");
  endtask : t_events

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  initial
  begin
    logic [7:0] codes [6] = '{8'h00, 8'h02, 8'h04, 8'h07, 8'h09, 8'h0c};
    int         ns [6] = '{DELAY_1_CYCLES, DELAY_3_CYCLES, DELAY_10_CYCLES, DELAY_86_CYCLES, N342, N2731};
    {rst_n, clk_en, bus_power_ok, bus_comm_ok, module_error, config_error} = 6'b011100;
    pins = 2'b00;
    lvl  = 2'b00;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    check(input_levels, 8'h00, "reset");
    t_reg();
    t_diag();
    t_leds();
    for (int i = 0; i < 6; i++)
      t_filter(0, codes[i], ns[i]);
    t_filter(1, DELAY_CODE_3US, DELAY_3_CYCLES);
    t_events();
    summarize();
  end
endmodule : dual_fast_digital_input_bench

// ==== testbench/head_station_model.sv ====
// Head station model: writes and reads back parameter bytes
`timescale 1ns/1ps
module head_station_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] param_rdata,
  input  wire logic       param_reject,
  output logic            system_stop,
  output logic            param_wr,
  output logic [2:0]      param_index,
  output logic [7:0]      param_wdata
);
  initial
  begin
    system_stop = 1'b0;
    param_wr    = 1'b0;
    param_index = 3'h0;
    param_wdata = 8'h00;
  end

  // Stop state only around a diag enable write, unless told to misbehave
  task automatic put(input logic [2:0] idx, input logic [7:0] d, input bit obey, output bit rej);
    @(negedge ref_clk);
    system_stop = obey && (idx == 3'h0);
    param_index = idx;
    param_wdata = d;
    param_wr    = 1'b1;
    @(negedge ref_clk);
    param_wr    = 1'b0;
    param_wdata = ~d;
    rej         = param_reject;
    @(negedge ref_clk);
    rej         = rej | param_reject;
    system_stop = 1'b0;
  endtask : put

  task automatic get(input logic [2:0] idx, output logic [7:0] d);
    @(negedge ref_clk);
    param_index = idx;
    repeat (2) @(negedge ref_clk);
    d = param_rdata;
  endtask : get
endmodule : head_station_model
